// ===== hw/imdp_pkg.sv
package imdp_pkg;
    // ****************************************
    // Register map and fields
    // ****************************************
    localparam logic [7:0] SUB_STATUS  = 8'h02;
    localparam logic [7:0] SUB_HEADER  = 8'h04;
    localparam logic [7:0] SUB_PAYLOAD = 8'h05;
    localparam logic [2:0] LAST_BYTE   = 3'h7;
    localparam logic [7:0] EOL_ERR     = 8'hf0;
    localparam logic [5:0] FLAGS_RST   = 6'h00;
    localparam int         BIT_INVALID = 5;
    localparam logic [15:0] MEM_FIRST_BAD = 16'h0007;
    // Memory codes
    localparam logic [2:0] MEM_UPROG  = 3'h0;
    localparam logic [2:0] MEM_UXDATA = 3'h1;
    localparam logic [2:0] MEM_DPROG  = 3'h2;
    localparam logic [2:0] MEM_DCOEF  = 3'h3;
    localparam logic [2:0] MEM_DDATA  = 3'h4;
    localparam logic [2:0] MEM_DUDATA = 3'h5;
    localparam logic [2:0] MEM_DUCOEF = 3'h6;
    localparam int FIFO_DEPTH = 32;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        IMDP_IDLE  = 2'b00,
        IMDP_DATA  = 2'b01,
        IMDP_CKSUM = 2'b10
    } imdp_load_e;

    // One 8-byte payload group on its way to memory
    typedef struct packed {
        logic [2:0]  sel;
        logic [15:0] addr;
        logic [63:0] bytes;
    } imdp_grp_s;
endpackage

// ===== hw/imdp_top.sv
`timescale 1ns/1ps
// ****************************************
// Group FIFO
// ****************************************
module imdp_fifo #(
    parameter int W = 83,
    parameter int D = 32
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wp;
    logic [AW:0]  rp;

    initial begin
        if (D < 2 || (D & (D - 1)) != 0) $error("imdp_fifo depth must be a power of two");
    end

    // Honest flags from the extra pointer bit
    assign in_ready  = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
    assign out_valid = (wp != rp);
    assign out_data  = mem[rp[AW-1:0]];

    // Write pointer and storage
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wp <= '0;
        end else if (in_valid && in_ready) begin
            wp <= wp + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem[wp[AW-1:0]] <= in_data;
        end
    end
    // Read pointer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rp <= '0;
        end else if (out_valid && out_ready) begin
            rp <= rp + 1'b1;
        end
    end

    a_no_overrun: assert property (@(posedge clk) disable iff (reset)
        !in_ready |=> wp == $past(wp)) else $error("fifo written while full");
endmodule // imdp_fifo

// ****************************************
// Memory download port
// ****************************************
module imdp_top
    import imdp_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Register port from the slave front end
    input  wire logic        reg_start,
    input  wire logic [7:0]  reg_sub,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    output logic             reg_busy,
    // Memory write port
    output logic             mem_we,
    output logic [2:0]       mem_sel,
    output logic [15:0]      mem_addr,
    output logic [53:0]      mem_wdata,
    input  wire logic        mem_ready,
    // Load state
    output logic             load_active,
    output logic             load_done,
    output logic [7:0]       status_low
);
    initial begin
        if (DEPTH < 2) $error("imdp_top fifo depth too small");
    end

    logic [7:0]  sub;
    logic [2:0]  idx;
    logic [63:0] hdr;
    logic        hdr_go;
    logic [15:0] sum;
    logic [5:0]  flags;
    logic        eol;
    imdp_load_e  st;
    logic [15:0] left;
    logic [2:0]  gcnt;
    logic [2:0]  cur_sel;
    logic [2:0]  cur_bit;
    logic [15:0] waddr;
    logic [63:0] grp;
    logic [7:0]  trail_hi;
    logic        tcnt;
    logic        drop;
    logic        push;
    imdp_grp_s   push_d;
    logic        f_in_ready;
    logic        f_out_valid;
    logic        f_out_ready;
    imdp_grp_s   f_out;
    logic        have;
    imdp_grp_s   g;
    logic [2:0]  k;

    wire hdr_wr = reg_wr && sub == SUB_HEADER;
    wire pay_wr = reg_wr && sub == SUB_PAYLOAD;
    wire [15:0] h_ck  = hdr[63:48];
    wire [15:0] h_mem = hdr[47:32];
    wire [15:0] h_adr = hdr[31:16];
    wire [15:0] h_cnt = hdr[15:0];
    wire [15:0] sum_n = sum + {8'h00, reg_wdata};
    wire        ok    = ({trail_hi, reg_wdata} == sum) && (sum == h_ck) && !drop;

    // Words per group and flag bit per memory type
    function automatic logic [3:0] nwords(input logic [2:0] s);
        unique case (s)
            MEM_UPROG, MEM_UXDATA: nwords = 4'h8;
            MEM_DCOEF, MEM_DUCOEF: nwords = 4'h2;
            default:               nwords = 4'h1;
        endcase
    endfunction
    function automatic logic [2:0] flag_bit(input logic [2:0] s);
        unique case (s)
            MEM_DCOEF, MEM_DUCOEF: flag_bit = 3'h3;
            MEM_DDATA, MEM_DUDATA: flag_bit = 3'h4;
            default:               flag_bit = s;
        endcase
    endfunction
    function automatic logic [53:0] word(input imdp_grp_s e, input logic [2:0] n);
        unique case (e.sel)
            MEM_UPROG, MEM_UXDATA: word = {46'h0, e.bytes[8*(7-n) +: 8]};
            MEM_DCOEF, MEM_DUCOEF: word = n[0] ? {26'h0, e.bytes[27:0]}
                                               : {26'h0, e.bytes[59:32]};
            MEM_DPROG:             word = e.bytes[53:0];
            default:               word = {6'h0, e.bytes[47:0]};
        endcase
    endfunction

    // Subaddress and byte index of the current register access
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sub <= 8'h00;
            idx <= 3'h0;
        end else if (reg_start) begin
            sub <= reg_sub;
            idx <= 3'h0;
        end else if (reg_wr || reg_rd) begin
            idx <= idx + 3'h1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hdr    <= 64'h0;
            hdr_go <= 1'b0;
        end else begin
            hdr_go <= hdr_wr && idx == LAST_BYTE;
            if (hdr_wr) hdr <= {hdr[55:0], reg_wdata};
        end
    end

    // running sum over header bytes 2-8 and data
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sum <= 16'h0;
        end else if (hdr_wr) begin
            sum <= (idx == 3'h0) ? 16'h0 : sum_n;
        end else if (pay_wr && st == IMDP_DATA) begin
            sum <= sum_n;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st       <= IMDP_IDLE;
            left     <= 16'h0;
            gcnt     <= 3'h0;
            grp      <= 64'h0;
            cur_sel  <= 3'h0;
            cur_bit  <= 3'h0;
            waddr    <= 16'h0;
            tcnt     <= 1'b0;
            trail_hi <= 8'h00;
            push     <= 1'b0;
            push_d   <= '0;
        end else begin
            push <= 1'b0;
            if (hdr_go && h_cnt != 16'h0 && h_mem < MEM_FIRST_BAD) begin
                st      <= IMDP_DATA;
                left    <= h_cnt;
                gcnt    <= 3'h0;
                grp     <= 64'h0;
                cur_sel <= h_mem[2:0];
                cur_bit <= flag_bit(h_mem[2:0]);
                waddr   <= h_adr;
                tcnt    <= 1'b0;
            end else if (hdr_go) begin
                st <= IMDP_IDLE;
            end else if (pay_wr && st == IMDP_DATA) begin
                grp[8*(7-gcnt) +: 8] <= reg_wdata;
                gcnt <= gcnt + 3'h1;
                left <= left - 16'h1;
                // Short last group goes out zero padded
                if (gcnt == LAST_BYTE || left == 16'h1) begin
                    push         <= 1'b1;
                    push_d.sel   <= cur_sel;
                    push_d.addr  <= waddr;
                    push_d.bytes <= grp;
                    push_d.bytes[8*(7-gcnt) +: 8] <= reg_wdata;
                    waddr <= waddr + {12'h0, nwords(cur_sel)};
                    grp   <= 64'h0;
                    gcnt  <= 3'h0;
                end
                if (left == 16'h1) st <= IMDP_CKSUM;
            end else if (pay_wr && st == IMDP_CKSUM) begin
                tcnt     <= 1'b1;
                trail_hi <= reg_wdata;
                if (tcnt) st <= IMDP_IDLE;
            end
        end
    end

    // A group pushed into a full FIFO is lost and fails the load
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            drop <= 1'b0;
        end else if (hdr_go) begin
            drop <= 1'b0;
        end else if (push && !f_in_ready) begin
            drop <= 1'b1;
        end
    end

    // Error flags, end-of-load and done
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flags     <= FLAGS_RST;
            eol       <= 1'b0;
            load_done <= 1'b0;
        end else if (hdr_go) begin
            if (h_cnt == 16'h0) begin
                load_done <= 1'b1;
                eol       <= (h_ck != 16'h0) || (h_adr != 16'h0);
            // codes 7 and above are an invalid select
            end else if (h_mem >= MEM_FIRST_BAD) begin
                flags[BIT_INVALID] <= 1'b1;
            end else begin
                flags[flag_bit(h_mem[2:0])] <= 1'b1;
                load_done <= 1'b0;
            end
        // only a good checksum clears the flag
        end else if (pay_wr && st == IMDP_CKSUM && tcnt && ok) begin
            flags[cur_bit] <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status_low  <= 8'h00;
            reg_rdata   <= 8'h00;
            load_active <= 1'b0;
            reg_busy    <= 1'b0;
        end else begin
            status_low  <= eol ? EOL_ERR : {2'b00, flags};
            load_active <= st != IMDP_IDLE;
            reg_busy    <= !f_in_ready;
            if (reg_rd) begin
                reg_rdata <= (sub == SUB_STATUS && idx[1:0] == 2'h3) ? status_low : 8'h00;
            end
        end
    end

    imdp_fifo #(.W($bits(imdp_grp_s)), .D(DEPTH)) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (push),
        .in_ready  (f_in_ready),
        .in_data   (push_d),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out)
    );
    assign f_out_ready = !have;

    // Drain: unpack each group into memory words, stalled by mem_ready
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            have      <= 1'b0;
            g         <= '0;
            k         <= 3'h0;
            mem_we    <= 1'b0;
            mem_sel   <= 3'h0;
            mem_addr  <= 16'h0;
            mem_wdata <= 54'h0;
        end else if (!have && f_out_valid) begin
            have      <= 1'b1;
            g         <= f_out;
            k         <= 3'h0;
            mem_we    <= 1'b1;
            mem_sel   <= f_out.sel;
            mem_addr  <= f_out.addr;
            mem_wdata <= word(f_out, 3'h0);
        end else if (mem_we && mem_ready) begin
            if ({1'b0, k} + 4'h1 < nwords(g.sel)) begin
                k         <= k + 3'h1;
                mem_addr  <= mem_addr + 16'h1;
                mem_wdata <= word(g, k + 3'h1);
            end else begin
                have   <= 1'b0;
                mem_we <= 1'b0;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_close_ok;
        pay_wr && st == IMDP_CKSUM && tcnt && ok;
    endsequence
    sequence s_close_bad;
        pay_wr && st == IMDP_CKSUM && tcnt && !ok;
    endsequence

    a_flag_set_uprog: assert property (@(posedge clk) disable iff (reset)
        hdr_go && h_cnt != 16'h0 && h_mem == 16'h0 |=> flags[0] ##1 status_low[0])
        else $error("load flag not raised");
    a_ok_clears: assert property (@(posedge clk) disable iff (reset)
        s_close_ok |=> !flags[$past(cur_bit)] && st == IMDP_IDLE)
        else $error("good load left flag set");
    a_bad_keeps: assert property (@(posedge clk) disable iff (reset)
        s_close_bad |=> flags == $past(flags)) else $error("bad load cleared flag");
    a_status_map: assert property (@(posedge clk) disable iff (reset)
        !eol |=> status_low == {2'b00, $past(flags)}) else $error("status byte wrong");
    a_invalid_sel: assert property (@(posedge clk) disable iff (reset)
        hdr_go && h_cnt != 16'h0 && h_mem >= MEM_FIRST_BAD |=> flags[BIT_INVALID]
        && st == IMDP_IDLE) else $error("invalid select accepted");
    a_term_header: assert property (@(posedge clk) disable iff (reset)
        hdr_go && hdr[47:0] == 48'h0 && h_ck == 16'h0 |=> load_done ##1
        status_low[7:6] == 2'b00) else $error("termination not taken");
    a_eol_error: assert property (@(posedge clk) disable iff (reset)
        hdr_go && h_cnt == 16'h0 && (h_ck != 16'h0 || h_adr != 16'h0) |=> ##1
        status_low == EOL_ERR)
        else $error("end-of-load error missing");
    a_hdr_eighth: assert property (@(posedge clk) disable iff (reset)
        hdr_wr && idx == 3'h6 |=> !hdr_go) else $error("header taken early");
    a_we_hold: assert property (@(posedge clk) disable iff (reset)
        mem_we && !mem_ready |=> mem_we && $stable(mem_addr) && $stable(mem_wdata))
        else $error("memory write dropped");
endmodule // imdp_top

// ===== sim/imdp_mem_sink.sv
`timescale 1ns/1ps
// *****
// Memory sink
// *****
module imdp_mem_sink
    import imdp_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Memory write port
    input  wire logic        mem_we,
    input  wire logic [2:0]  mem_sel,
    input  wire logic [15:0] mem_addr,
    input  wire logic [53:0] mem_wdata,
    output logic             mem_ready,
    // Test control
    input  wire logic        stall,
    input  wire logic        slow
);
    logic [72:0] got[$];
    logic        tick;

    // Slow mode accepts every other cycle to stretch each word
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tick <= 1'b0;
        end else begin
            tick <= ~tick;
        end
    end
    assign mem_ready = !stall && (!slow || tick);

    // A word lands only at an edge where request and ready meet
    always @(posedge clk) begin
        if (!reset && mem_we && mem_ready) begin
            got.push_back({mem_sel, mem_addr, mem_wdata});
        end
    end
endmodule // imdp_mem_sink

// ===== sim/test_i2c_memory_download_port.sv
`timescale 1ns/1ps
module test_i2c_memory_download_port
    import imdp_pkg::*;
;
    logic        clk = 1'b0, reset = 1'b1, reg_start = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  reg_sub = 8'h00, reg_wdata = 8'h00, reg_rdata, status_low, expst;
    logic        stall = 1'b0, slow = 1'b0, busy_seen = 1'b0;
    logic        reg_busy, mem_we, mem_ready, load_active, load_done;
    logic [2:0]  mem_sel;
    logic [15:0] mem_addr;
    logic [53:0] mem_wdata;
    logic [31:0] st;
    int          err_count = 0;
    int          tests_run = 0;

    always #12.5 clk = ~clk;

    // Small FIFO so that a short stall already fills it
    imdp_top #(.DEPTH(2)) u_imdp_top (.clk(clk), .reset(reset), .reg_start(reg_start),
        .reg_sub(reg_sub), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_busy(reg_busy), .mem_we(mem_we), .mem_sel(mem_sel),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready),
        .load_active(load_active), .load_done(load_done), .status_low(status_low));
    imdp_mem_sink u_imdp_mem_sink (.clk(clk), .reset(reset), .mem_we(mem_we),
        .mem_sel(mem_sel), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ready(mem_ready), .stall(stall), .slow(slow));

    // *****
    // Access tasks
    // *****
    task automatic check(input logic [72:0] got, input logic [72:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Every byte written, header or payload, waits while the FIFO is full
    task automatic wr_reg(input logic [7:0] sub, input logic [7:0] b[$]);
        @(posedge clk);
        reg_start <= 1'b1;
        reg_sub   <= sub;
        foreach (b[i]) begin
            @(negedge clk);
            for (int k = 0; k < 2000 && reg_busy !== 1'b0; k++) begin
                busy_seen = 1'b1;
                @(negedge clk);
            end
            @(posedge clk);
            reg_start <= 1'b0;
            reg_wr    <= 1'b1;
            reg_wdata <= b[i];
            @(posedge clk);
            reg_wr    <= 1'b0;
        end
    endtask

    task automatic rd_status(output logic [31:0] v);
        @(posedge clk);
        reg_start <= 1'b1;
        reg_sub   <= SUB_STATUS;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            reg_start <= 1'b0;
            reg_rd    <= 1'b1;
            @(posedge clk);
            reg_rd    <= 1'b0;
            @(negedge clk);
            v = {v[23:0], reg_rdata};
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    function automatic logic [7:0] flag(input logic [2:0] c);
        case (c)
            MEM_UPROG:             return 8'h01;
            MEM_UXDATA:            return 8'h02;
            MEM_DPROG:             return 8'h04;
            MEM_DCOEF, MEM_DUCOEF: return 8'h08;
            default:               return 8'h10;
        endcase
    endfunction

    function automatic logic [53:0] word(input logic [2:0] c, input logic [7:0] d[$], int j);
        case (c)
            MEM_UPROG, MEM_UXDATA: return {46'h0, d[j]};
            MEM_DCOEF, MEM_DUCOEF: return {26'h0, d[4*j][3:0], d[4*j+1], d[4*j+2], d[4*j+3]};
            default: return {d[8*j+1][5:0], d[8*j+2], d[8*j+3], d[8*j+4], d[8*j+5],
                             d[8*j+6], d[8*j+7]};
        endcase
    endfunction

    // One download block; bad spoils the header checksum
    task automatic load(input logic [2:0] c, input logic [15:0] a, input int n, input logic bad);
        logic [7:0]  h[$];
        logic [7:0]  d[$];
        logic [15:0] s;
        int          nw;
        s = 16'(c) + 16'(a[15:8]) + 16'(a[7:0]) + 16'(n / 256) + 16'(n % 256);
        for (int i = 0; i < n - 1; i++) begin
            d.push_back((i % 8 < 2) ? 8'h00 : (i % 8 == 4) ? 8'h05 : 8'(8'h11 * i + 8'h20));
            s = s + 16'(d[i]);
        end
        d.push_back(8'(-s[7:0]));
        s = s + 16'(d[n-1]);
        h = '{s[15:8] + 8'(bad), 8'h00, 8'h00, 8'(c), a[15:8], a[7:0], 8'(n / 256), 8'(n % 256)};
        nw = (c < 2) ? n : (c == 3 || c == 6) ? n / 4 : n / 8;
        u_imdp_mem_sink.got.delete();
        wr_reg(SUB_HEADER, h);
        settle(5);
        expst = expst | flag(c);
        check(status_low, expst, "flag on header");
        check(load_active, 1'b1, "load open");
        rd_status(st);
        check(st, {24'h0, expst}, "status read");
        d.push_back(s[15:8]);
        d.push_back(s[7:0]);
        wr_reg(SUB_PAYLOAD, d);
        settle(4);
        if (!bad) expst = expst & ~flag(c);
        check(status_low, expst, "flag after block");
        check(load_active, 1'b0, "load closed");
        for (int k = 0; k < 800 && u_imdp_mem_sink.got.size() < nw; k++) @(posedge clk);
        if (!bad) begin
            check(u_imdp_mem_sink.got.size(), nw, "word count");
            foreach (u_imdp_mem_sink.got[j]) begin
                check(u_imdp_mem_sink.got[j], {c, a + 16'(j), word(c, d, j)}, "word");
            end
        end
    endtask

    task automatic conclude();
        $display("Counts: %0d checks, %0d mismatches", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // *****
    // Tests
    // *****
    initial begin
        expst = 8'h00;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        settle(1);
        check({status_low, load_active, load_done, reg_busy, mem_we}, 12'h0, "reset outputs");
        rd_status(st);
        check(st, 32'h0, "reset status");
        $display("Test reset done");
        // every memory code loaded through the port
        for (int c = 0; c < 7; c++) begin
            @(posedge clk);
            slow <= c[0];
            load(3'(c), 16'h0100 + 16'(16 * c), 16, 1'b0);
        end
        $display("Test memory codes done");
        load(MEM_DPROG, 16'h0040, 8, 1'b1);
        load(MEM_DPROG, 16'h0040, 8, 1'b0);
        $display("Test checksum done");
        @(posedge clk);
        stall <= 1'b1;
        fork
            begin
                repeat (150) @(posedge clk);
                stall <= 1'b0;
            end
        join_none
        load(MEM_UPROG, 16'h0200, 40, 1'b0);
        check(busy_seen, 1'b1, "fifo refused");
        $display("Test fifo fill done");
        u_imdp_mem_sink.got.delete();
        for (int i = 0; i < 2; i++) begin
            wr_reg(SUB_HEADER, '{8'h00, 8'h00, 8'h00, i ? 8'h0f : 8'h07,
                                 8'h00, 8'h00, 8'h00, 8'h08});
            wr_reg(SUB_PAYLOAD, '{8'h01, 8'h02, 8'h03, 8'h04,
                                  8'h05, 8'h06, 8'h07, 8'h08});
            settle(6);
            check(status_low, 8'h20, "invalid select");
            check(load_active, 1'b0, "no load opened");
        end
        check(u_imdp_mem_sink.got.size(), 0, "no words written");
        $display("Test invalid code done");
        wr_reg(SUB_HEADER, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        settle(5);
        check(load_done, 1'b1, "end of download");
        check(status_low, 8'h20, "status kept");
        wr_reg(SUB_HEADER, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h12, 8'h00, 8'h00});
        settle(5);
        check(status_low, EOL_ERR, "end header error");
        // Mid-run reset, moved on the rising edge like every other input
        @(posedge clk);
        reset <= 1'b1;
        settle(2);
        @(posedge clk);
        reset <= 1'b0;
        settle(1);
        check(status_low, 8'h00, "status after reset");
        $display("Test termination done");
        conclude();
    end

    // Whole run needs about a thousand cycles
    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        $display("ERROR t=%0t watchdog expired", $time);
        conclude();
    end
endmodule // test_i2c_memory_download_port
